// ===== rtl/qdb_ctrl.sv
// double buffer control core of the quad serial converter with register slave
//
// Behaviour
// - output latch low makes all four converter registers follow their input registers.
// - output latch high makes all four converter registers hold their codes while the control force bit is clear.
// - input latch low makes the selected input register follow the received code.
// - input latch high keeps the selected input register unchanged despite serial traffic.
// - reset low forces every input and converter register to the reset code.
// - reset code is 000 with select low and 800 with select high.
// - a transfer is 16 bits: 12-bit code, 2-bit channel address, two unused.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module qdb_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_clk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    input wire logic input_latch_enable_n,
    input wire logic output_latch_enable_n,
    input wire logic dac_reset_n,
    input wire logic reset_code_select,
    output var logic [qdb_pkg::CHAN_N-1:0][qdb_pkg::CODE_W-1:0] dac_code,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [qdb_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [qdb_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [qdb_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [qdb_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import qdb_pkg::*;

    typedef struct packed {
        logic [1:0] rst_s;
        logic [1:0] rsel_s;
        logic [1:0] il_s;
        logic [1:0] ol_s;
        logic [2:0] tog_s;
        logic [11:0] code;
        logic [1:0] sel;
        logic seen;
        logic [15:0] count;
        logic [3:0][11:0] inp;
        logic [3:0][11:0] dac;
        logic accept;
        logic force_load;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } qdb_state_t;

    qdb_state_t st;
    qdb_state_t next_st;
    qdb_link_if lnk ();
    logic word_evt;
    logic transparent;
    logic [32:0] rd;
    logic [11:0] async_code;

    // ------------------------------------------------------------
    // serial receiver on the link clock
    // ------------------------------------------------------------
    qdb_link_rx u_rx
    (
        .serial_clk(serial_clk),
        .aresetn(aresetn),
        .cs_n(cs_n),
        .serial_data_in(serial_data_in),
        .lnk(lnk)
    );

    function automatic logic [32:0] reg_read(input logic [7:0] addr, input qdb_state_t s);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (addr == REG_CTRL)
        begin
            r = {1'b1, 30'h0000_0000, s.force_load, s.accept};
        end
        else if (addr == REG_STATUS)
        begin
            r = {1'b1, s.count, 10'h000, s.rst_s[1], s.ol_s[1], s.il_s[1], s.seen, s.sel};
        end
        else if (addr[1:0] == 2'h0 && addr[7:4] == REG_INPUT_PAGE)
        begin
            r = {1'b1, 20'h00000, s.inp[addr[3:2]]};
        end
        else if (addr[1:0] == 2'h0 && addr[7:4] == REG_DAC_PAGE)
        begin
            r = {1'b1, 20'h00000, s.dac[addr[3:2]]};
        end
        return r;
    endfunction : reg_read

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // the word itself is not synchronised: it has stood still for two or more
    // aclk cycles before its toggle reaches the far end of the synchroniser
    assign word_evt = st.tog_s[2] ^ st.tog_s[1];
    assign transparent = !st.ol_s[1] || st.force_load;
    assign rd = reg_read(s_axi_araddr, st);

    always_comb
    begin
        next_st = st;
        next_st.rst_s = {st.rst_s[0], dac_reset_n};
        next_st.rsel_s = {st.rsel_s[0], reset_code_select};
        next_st.il_s = {st.il_s[0], input_latch_enable_n};
        next_st.ol_s = {st.ol_s[0], output_latch_enable_n};
        next_st.tog_s = {st.tog_s[1:0], lnk.toggle};

        if (word_evt && st.accept)
        begin
            next_st.code = lnk.word[11:0];
            next_st.sel = lnk.word[WORD_ADDR_LSB +: 2];
            next_st.seen = 1'b1;
            next_st.count = st.count + 16'h0001;
        end
        if (!st.il_s[1])
        begin
            next_st.inp[st.sel] = st.code;
        end
        // input latch high: only the reset term writes the input registers
        if (transparent)
        begin
            next_st.dac = st.inp;
        end
        // output latch high and force_load clear: only the reset term writes the converter registers
        if (!st.rst_s[1])
        begin
            for (int i = 0; i < CHAN_N; i++)
            begin
                next_st.inp[i] = qdb_reset_code(st.rsel_s[1]);
                next_st.dac[i] = qdb_reset_code(st.rsel_s[1]);
            end
        end

        // write channel: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_SLVERR;
            if (st.awaddr == REG_CTRL)
            begin
                next_st.bresp = RESP_OKAY;
                if (st.wstrb[0])
                begin
                    next_st.accept = st.wdata[CTRL_ACCEPT_BIT];
                    next_st.force_load = st.wdata[CTRL_FORCE_BIT];
                end
            end
            else if (reg_read(st.awaddr, st) != {1'b0, 32'h0000_0000})
            begin
                // read-only registers take the write silently
                next_st.bresp = RESP_OKAY;
            end
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // read channel
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd[31:0];
            next_st.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '{accept: CTRL_ACCEPT_RESET, force_load: CTRL_FORCE_RESET, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the reset pin acts on the outputs at once, without waiting for aclk
    assign async_code = qdb_reset_code(reset_code_select);
    always_comb
    begin
        for (int i = 0; i < CHAN_N; i++)
        begin
            dac_code[i] = dac_reset_n ? st.dac[i] : async_code;
        end
    end

    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_dac_follow: assert property ((st.rst_s[1] && transparent) |=> st.dac == $past(st.inp))
        else $error("converter registers did not follow input registers");
    a_dac_hold: assert property ((st.rst_s[1] && !transparent) |=> $stable(st.dac))
        else $error("converter registers changed while latched");
    a_inp_follow: assert property ((st.rst_s[1] && !st.il_s[1])
        |=> st.inp[$past(st.sel)] == $past(st.code))
        else $error("selected input register did not take the code");
    a_inp_hold: assert property ((st.rst_s[1] && st.il_s[1]) |=> $stable(st.inp))
        else $error("input registers changed while latched");
    a_reset_mid: assert property ((!st.rst_s[1] && st.rsel_s[1])
        |=> (st.inp[3] == CODE_MID_SCALE && st.dac[0] == CODE_MID_SCALE))
        else $error("reset did not load mid-scale");
    a_reset_zero: assert property ((!st.rst_s[1] && !st.rsel_s[1])
        |=> (st.inp[0] == CODE_ZERO_SCALE && st.dac[3] == CODE_ZERO_SCALE))
        else $error("reset did not load zero-scale");
    a_pin_reset: assert property ((!dac_reset_n && reset_code_select)
        |-> dac_code[1] == CODE_MID_SCALE)
        else $error("reset pin did not reach the outputs");
    a_word_split: assert property ((word_evt && st.accept)
        |=> (st.code == $past(lnk.word[11:0]) && st.sel == $past(lnk.word[15:14])))
        else $error("received word split wrongly");
    a_bresp_hold: assert property ((st.bvalid && !s_axi_bready) |=> (st.bvalid && $stable(st.bresp)))
        else $error("write response dropped before taken");
    a_pin_zero: assert property ((!dac_reset_n && !reset_code_select)
        |-> dac_code[2] == CODE_ZERO_SCALE)
        else $error("reset pin did not give zero-scale");
    a_word_drop: assert property ((word_evt && !st.accept)
        |=> (st.code == $past(st.code) && st.count == $past(st.count)))
        else $error("refused word was taken");
    a_word_count: assert property ((word_evt && st.accept)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("accepted word count did not step");

    // ------------------------------------------------------------
    // register bus checks
    // ------------------------------------------------------------
    a_rresp_hold: assert property ((st.rvalid && !s_axi_rready)
        |=> (st.rvalid && $stable(st.rdata) && $stable(st.rresp)))
        else $error("read response dropped before taken");
    a_write_answer: assert property ((st.aw_got && st.w_got) |=> st.bvalid)
        else $error("write gave no response");
    a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> st.rvalid)
        else $error("read gave no response");
    a_ready_busy: assert property (st.bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write taken while response pending");
    a_bvalid_clear: assert property ((st.bvalid && s_axi_bready) |=> !st.bvalid)
        else $error("write response not released");
    a_rvalid_clear: assert property ((st.rvalid && s_axi_rready) |=> !st.rvalid)
        else $error("read response not released");
    a_ctrl_write: assert property ((st.aw_got && st.w_got && st.awaddr == REG_CTRL && st.wstrb[0])
        |=> (st.accept == $past(st.wdata[0]) && st.force_load == $past(st.wdata[1])))
        else $error("control write did not land");

    c_word_seen: cover property (word_evt && st.accept);
    c_dac_update: cover property (transparent && st.dac != st.inp);
    c_reset_mid: cover property (!st.rst_s[1] && st.rsel_s[1]);
    c_axi_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
    c_force_load: cover property (st.force_load && st.ol_s[1] && st.dac != st.inp);

endmodule : qdb_ctrl
`default_nettype wire

// ===== rtl/qdb_link_if.sv
// word and event toggle carried from the serial receiver to the control core
`timescale 1ns/100ps
`default_nettype none
interface qdb_link_if;
    logic [15:0] word;
    logic toggle;
    modport link (output word, output toggle);
    modport core (input word, input toggle);
endinterface : qdb_link_if
`default_nettype wire

// ===== rtl/qdb_link_rx.sv
// serial word receiver running on the link clock
`timescale 1ns/100ps
`default_nettype none
module qdb_link_rx
(
    input wire logic serial_clk,
    input wire logic aresetn,
    input wire logic cs_n,
    input wire logic serial_data_in,
    qdb_link_if.link lnk
);
    import qdb_pkg::*;

    typedef struct packed {
        logic cs_idle;
        logic [4:0] count;
        logic [15:0] shift;
        logic [15:0] word;
        logic toggle;
    } qdb_rx_state_t;

    qdb_rx_state_t st;
    qdb_rx_state_t next_st;
    logic [15:0] next_shift;

    // ------------------------------------------------------------
    // shift and frame
    // ------------------------------------------------------------
    // the link clock may stand still outside frames, so a frame start is
    // seen from the idle flag captured on the last edge, not from a later edge
    always_comb
    begin
        next_st = st;
        next_shift = {st.shift[14:0], serial_data_in};
        next_st.cs_idle = cs_n;
        if (!cs_n)
        begin
            next_st.shift = next_shift;
            if (st.cs_idle || st.count == WORD_BITS)
            begin
                next_st.count = BIT_COUNT_FIRST;
            end
            else
            begin
                next_st.count = st.count + BIT_COUNT_FIRST;
            end
            if (next_st.count == WORD_BITS)
            begin
                next_st.word = next_shift;
                next_st.toggle = ~st.toggle;
            end
        end
    end

    // asynchronous clear to constants: the link clock may not run in reset
    always_ff @(posedge serial_clk or negedge aresetn)
    begin
        if (!aresetn)
        begin
            st <= '{cs_idle: 1'b1, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign lnk.word = st.word;
    assign lnk.toggle = st.toggle;

endmodule : qdb_link_rx
`default_nettype wire

// ===== rtl/qdb_pkg.sv
// constants, widths and the register map of the quad converter double buffer control
package qdb_pkg;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int CHAN_N = 4;
    localparam int WORD_W = 16;
    localparam int WORD_ADDR_LSB = 14;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] BIT_COUNT_FIRST = 5'h01;
    localparam logic [11:0] CODE_ZERO_SCALE = 12'h000;
    localparam logic [11:0] CODE_MID_SCALE = 12'h800;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [3:0] REG_INPUT_PAGE = 4'h1;
    localparam logic [3:0] REG_DAC_PAGE = 4'h2;
    localparam int CTRL_ACCEPT_BIT = 0;
    localparam int CTRL_FORCE_BIT = 1;
    localparam logic CTRL_ACCEPT_RESET = 1'b1;
    localparam logic CTRL_FORCE_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [11:0] qdb_reset_code(input logic mid_scale);
        return mid_scale ? CODE_MID_SCALE : CODE_ZERO_SCALE;
    endfunction : qdb_reset_code

endpackage : qdb_pkg

// ===== tb/qdb_host_model.sv
// host controller model driving the serial link and latch pins
`timescale 1ns/100ps
`default_nettype none
module qdb_host_model
(
    input wire logic aclk,
    output logic serial_clk,
    output logic cs_n,
    output logic serial_data_in,
    output logic input_latch_enable_n,
    output logic output_latch_enable_n
);
    // ------------------------------------------------------------
    // frames and latch strobes
    // ------------------------------------------------------------
    initial
    begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        serial_data_in = 1'b0;
        input_latch_enable_n = 1'b1;
        output_latch_enable_n = 1'b1;
    end

    // clock stands still outside frames; 80 ns period, msb first
    task automatic send(input logic [15:0] w);
        #7;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            serial_data_in = w[i];
            #40 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
        #40 cs_n = 1'b1;
        // released line shows no stale bit
        serial_data_in = ~serial_data_in;
    endtask : send

    // levels set at an edge, then held n cycles; width n varies to be slow or brisk
    task automatic latch(input logic inl, input logic outl, input int n);
        @(posedge aclk);
        input_latch_enable_n <= inl;
        output_latch_enable_n <= outl;
        repeat (n) @(posedge aclk);
    endtask : latch
endmodule : qdb_host_model
`default_nettype wire

// ===== tb/tb_quad_dac_double_buffer_ctrl.sv
// self-checking bench of the quad converter double buffer control
`timescale 1ns/100ps
`default_nettype none
module tb_quad_dac_double_buffer_ctrl;
    import qdb_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    typedef struct packed {logic [15:0] word; logic [1:0] ch; logic [11:0] code;} qdb_row_t;
    logic aclk, aresetn, dac_reset_n, reset_code_select;
    logic serial_clk, cs_n, serial_data_in, input_latch_enable_n, output_latch_enable_n;
    logic [CHAN_N-1:0][CODE_W-1:0] dac_code;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [11:0] exp_dac [CHAN_N];
    logic [31:0] rdat;
    int err_count = 0;
    int n_compared = 0;
    // unused bits set in some words: they must not leak into the code
    qdb_row_t rows [6] = '{'{16'h3fff, 2'h0, 12'hfff}, '{16'h4001, 2'h1, 12'h001},
        '{16'h9a5a, 2'h2, 12'ha5a}, '{16'hc800, 2'h3, 12'h800},
        '{16'h0000, 2'h0, 12'h000}, '{16'he5a5, 2'h3, 12'h5a5}};

    qdb_host_model host (.aclk, .serial_clk, .cs_n, .serial_data_in, .input_latch_enable_n,
        .output_latch_enable_n);
    qdb_ctrl dut (.aclk, .aresetn, .serial_clk, .cs_n, .serial_data_in, .input_latch_enable_n,
        .output_latch_enable_n, .dac_reset_n, .reset_code_select, .dac_code, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
            if (s_axi_wvalid && s_axi_wready) dd = 1'b1;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !dd;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a, rdat, resp);
        check("read data", rdat, e);
        check("read resp", 32'(resp), 32'(er));
    endtask : rchk

    task automatic dacs();
        for (int i = 0; i < CHAN_N; i++)
            check("converter code", 32'(dac_code[i]), 32'(exp_dac[i]));
    endtask : dacs

    // word, settle in core, then an input latch pulse
    task automatic load(input logic [15:0] w);
        host.send(w);
        host.latch(1'b1, 1'b1, 8);
        host.latch(1'b0, 1'b1, 6);
        host.latch(1'b1, 1'b1, 6);
    endtask : load

    task automatic update();
        host.latch(1'b1, 1'b0, 6);
        host.latch(1'b1, 1'b1, 6);
    endtask : update

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        err_count++;
        stop_test();
    end

    initial
    begin
        aresetn = 1'b0;
        dac_reset_n = 1'b1;
        reset_code_select = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        exp_dac = '{default: CODE_ZERO_SCALE};
        dacs();
        rchk(REG_CTRL, 32'h1, RESP_OKAY);
        rchk(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h44, 32'h0, resp);
        check("write resp", 32'(resp), 32'(RESP_SLVERR));
        wr(REG_CTRL, 32'h1, resp);
        check("write resp", 32'(resp), 32'(RESP_OKAY));
        foreach (rows[i])
        begin
            load(rows[i].word);
            rchk({REG_INPUT_PAGE, rows[i].ch, 2'h0}, 32'(rows[i].code), RESP_OKAY);
            update();
            exp_dac[rows[i].ch] = rows[i].code;
            dacs();
        end
        // all four inputs loaded while outputs hold, then one shared update
        for (int c = 0; c < CHAN_N; c++)
            load({2'(c), 2'h0, 12'(12'h111 * (c + 1))});
        dacs();
        update();
        for (int c = 0; c < CHAN_N; c++)
        begin
            exp_dac[c] = 12'(12'h111 * (c + 1));
            rchk({REG_DAC_PAGE, 2'(c), 2'h0}, 32'(exp_dac[c]), RESP_OKAY);
        end
        dacs();
        host.latch(1'b0, 1'b1, 2);
        host.send(16'h4123);
        host.latch(1'b0, 1'b1, 8);
        rchk(8'h14, 32'h123, RESP_OKAY);
        host.latch(1'b1, 1'b1, 4);
        host.send(16'h4456);
        host.latch(1'b1, 1'b1, 8);
        rchk(8'h14, 32'h123, RESP_OKAY);
        // twelve words taken so far, last to channel 1, all pins high
        rchk(REG_STATUS, 32'h000c_003d, RESP_OKAY);
        // words refused, converters forced transparent
        wr(REG_CTRL, 32'h2, resp);
        check("write resp", 32'(resp), 32'(RESP_OKAY));
        host.latch(1'b1, 1'b1, 4);
        exp_dac[1] = 12'h123;
        dacs();
        // dropped word: the input register takes the last accepted code
        load(16'h4777);
        rchk(8'h14, 32'h456, RESP_OKAY);
        exp_dac[1] = 12'h456;
        dacs();
        for (int s = 0; s < 2; s++)
        begin
            @(posedge aclk);
            reset_code_select <= 1'(s);
            dac_reset_n <= 1'b0;
            repeat (6) @(posedge aclk);
            exp_dac = '{default: (s != 0) ? CODE_MID_SCALE : CODE_ZERO_SCALE};
            dacs();
            @(posedge aclk);
            dac_reset_n <= 1'b1;
            repeat (6) @(posedge aclk);
            dacs();
            rchk(8'h14, 32'(exp_dac[1]), RESP_OKAY);
        end
        stop_test();
    end
endmodule : tb_quad_dac_double_buffer_ctrl
`default_nettype wire
